// [hpag_pkg.sv]
// Constants shared by the host port alignment and pin guard block
package hpag_pkg;

	// ------------------------------------------------------------
	// Register word offsets on the Avalon-MM slave
	// ------------------------------------------------------------
	localparam int          ADDR_W       = 3;
	localparam logic [2:0]  REG_CTRL     = 3'h0;
	localparam logic [2:0]  REG_WINDOW   = 3'h1;
	localparam logic [2:0]  REG_AUX      = 3'h2;
	localparam logic [2:0]  REG_PFC      = 3'h3;
	localparam logic [2:0]  REG_STAT     = 3'h4;

	// ------------------------------------------------------------
	// Control register fields
	// ------------------------------------------------------------
	localparam int          CTRL_SWAP    = 0;
	localparam int          CTRL_ORDER   = 1;
	localparam int          CTRL_HALF    = 2;
	localparam int          CTRL_IRQ     = 4;
	localparam int          CTRL_DREQ    = 5;
	localparam logic [1:0]  HALF_UPPER   = 2'h0;
	localparam logic [1:0]  HALF_LOWER   = 2'h2;
	localparam logic [31:0] CTRL_RESET   = 32'h00000000;

	// ------------------------------------------------------------
	// Pin groups and pin function control fields
	// ------------------------------------------------------------
	localparam int          NGROUP       = 8;
	localparam int          G_READY      = 0;
	localparam int          G_IRQ        = 1;
	localparam int          G_DREQ       = 2;
	localparam int          G_DATA       = 3;
	localparam int          G_SEL        = 4;
	localparam int          G_RSEL       = 5;
	localparam int          G_WR         = 6;
	localparam int          G_RD         = 7;
	localparam int          PFC_EBL      = 0;
	localparam int          PFC_GRP      = 1;
	localparam logic [8:0]  PFC_RESET    = 9'h000;

	// ------------------------------------------------------------
	// Status register fields and synchroniser layout
	// ------------------------------------------------------------
	localparam int          STAT_BOOT    = 0;
	localparam int          STAT_EBL     = 1;
	localparam int          STAT_PINS    = 8;
	localparam int          PIN_W        = 22;
	localparam int          P_BOOT       = 0;
	localparam int          P_EBL        = 1;
	localparam int          P_SEL        = 2;
	localparam int          P_RSEL       = 3;
	localparam int          P_WR         = 4;
	localparam int          P_RD         = 5;
	localparam int          P_DATA       = 6;

endpackage : hpag_pkg

// [hpag_align.sv]
// Lane alignment between a 32-bit register and the 16 data pins
module hpag_align
	import hpag_pkg::*;
(
	input  wire logic [31:0] word,
	input  wire logic        swap,
	input  wire logic        half_order,
	input  wire logic [1:0]  half_sel,
	input  wire logic        is_window,
	input  wire logic [15:0] pin_data,
	output logic      [15:0] pin_word,
	output logic      [31:0] merged
);

	logic        upper;
	logic        swap_eff;
	logic        src_up;
	logic [15:0] half;
	logic [15:0] wdat;

	// Only bit 1 of the half field selects; order bit reverses it
	always_comb begin
		upper    = (half_sel[1] == HALF_UPPER[1]) ^ half_order;
		swap_eff = swap & is_window;
		// Swap reverses all four bytes, so it also flips the half
		src_up   = upper ^ swap_eff;
		half     = src_up ? word[31:16] : word[15:0];
		pin_word = swap_eff ? {half[7:0], half[15:8]} : half;
		wdat     = swap_eff ? {pin_data[7:0], pin_data[15:8]} : pin_data;
		merged   = src_up ? {wdat, word[15:0]} : {word[31:16], wdat};
	end

endmodule : hpag_align

// [hpag_top.sv]
// Host port data alignment and pin buffer guard with Avalon-MM registers
//
// Implementation choices: the address map and the Avalon-MM register port.
module hpag_top
	import hpag_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              rst,
	input  wire logic [ADDR_W-1:0] avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic      [31:0]       avs_readdata,
	output logic                   avs_waitrequest,
	input  wire logic              boot_mode_in,
	input  wire logic              port_enable_in,
	input  wire logic              port_select_in,
	input  wire logic              register_select_in,
	input  wire logic              write_strobe_in,
	input  wire logic              read_strobe_in,
	input  wire logic [15:0]       host_data_pins_in,
	output logic      [15:0]       host_data_pins_out,
	output logic                   host_data_pins_oe,
	output logic                   ready_out,
	output logic                   ready_oe,
	output logic                   irq_out,
	output logic                   irq_oe,
	output logic                   dma_request_out,
	output logic                   dma_request_oe,
	output logic      [NGROUP-1:0] pin_in_buf_en
);

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [PIN_W-1:0] pin_meta;
	logic [PIN_W-1:0] pin_s;
	logic             wr_prev;

	always_ff @(posedge clock) begin
		pin_meta <= {host_data_pins_in, read_strobe_in, write_strobe_in,
			register_select_in, port_select_in, port_enable_in,
			boot_mode_in};
		pin_s    <= pin_meta;
	end

	logic        ebl_s;
	logic        sel_s;
	logic        rsel_s;
	logic        wr_s;
	logic        rd_s;
	logic [15:0] data_s;

	assign ebl_s  = pin_s[P_EBL];
	assign sel_s  = pin_s[P_SEL];
	assign rsel_s = pin_s[P_RSEL];
	assign wr_s   = pin_s[P_WR];
	assign rd_s   = pin_s[P_RD];
	assign data_s = pin_s[P_DATA +: 16];

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [31:0]   ctrl;
	logic [31:0]   window;
	logic [31:0]   aux;
	logic [8:0]    pin_function_ctrl;
	logic          boot;
	logic          dreq_flag;
	logic [NGROUP-1:0] gate;
	logic          bus_req;
	logic          bus_done;
	logic          host_commit;
	logic          host_rd_start;
	logic [15:0]   win_pins;
	logic [15:0]   aux_pins;
	logic [31:0]   win_merged;
	logic [31:0]   aux_merged;

	assign bus_req  = avs_read | avs_write;
	assign bus_done = bus_req & ~avs_waitrequest;

	// Boot level caught while reset is held
	always_ff @(posedge clock) begin
		if (rst) begin
			boot <= pin_s[P_BOOT];
		end
	end

	// ------------------------------------------------------------
	// Pin function gating per group
	// ------------------------------------------------------------
	logic              ebl_fn;
	logic [NGROUP-1:0] next_gate;

	assign ebl_fn = boot | pin_function_ctrl[PFC_EBL];

	genvar g;
	generate
		for (g = 0; g < NGROUP; g++) begin : g_gate
			always_comb begin
				// Enable pin lacking host function forces this group off
				next_gate[g] = (boot | pin_function_ctrl[PFC_GRP + g]) & ebl_fn
					& ebl_s;
			end
		end
	endgenerate

	always_ff @(posedge clock) begin
		if (rst) begin
			gate <= '0;
		end else begin
			gate <= next_gate;
		end
	end

	// ------------------------------------------------------------
	// Host access detection
	// ------------------------------------------------------------
	logic strobes_on;

	assign strobes_on = gate[G_SEL] & gate[G_RSEL] & gate[G_WR]
		& gate[G_RD] & gate[G_DATA];

	always_ff @(posedge clock) begin
		if (rst) begin
			wr_prev <= 1'b0;
		end else begin
			wr_prev <= wr_s & strobes_on;
		end
	end

	// Write commits on the trailing edge of the write strobe
	assign host_commit   = wr_prev & ~wr_s & sel_s & strobes_on;
	// Read start pulses once, before the data pins are driven
	assign host_rd_start = sel_s & rd_s & strobes_on & ~host_data_pins_oe;

	hpag_align u_win (
		.word       (window),
		.swap       (ctrl[CTRL_SWAP]),
		.half_order (ctrl[CTRL_ORDER]),
		.half_sel   (ctrl[CTRL_HALF +: 2]),
		.is_window  (1'b1),
		.pin_data   (data_s),
		.pin_word   (win_pins),
		.merged     (win_merged)
	);

	hpag_align u_aux (
		.word       (aux),
		.swap       (ctrl[CTRL_SWAP]),
		.half_order (ctrl[CTRL_ORDER]),
		.half_sel   (ctrl[CTRL_HALF +: 2]),
		.is_window  (1'b0),
		.pin_data   (data_s),
		.pin_word   (aux_pins),
		.merged     (aux_merged)
	);

	// ------------------------------------------------------------
	// Avalon-MM slave: one wait cycle per access
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
		end else if (bus_req && avs_waitrequest) begin
			avs_waitrequest <= 1'b0;
		end else begin
			avs_waitrequest <= 1'b1;
		end
	end

	// Read data captured in the wait cycle, shown when wait drops
	always_ff @(posedge clock) begin
		if (rst) begin
			avs_readdata <= '0;
		end else if (avs_read && avs_waitrequest) begin
			case (avs_address)
				REG_CTRL:   avs_readdata <= {ctrl[31:CTRL_DREQ + 1],
					dreq_flag, ctrl[CTRL_DREQ - 1:0]};
				REG_WINDOW: avs_readdata <= window;
				REG_AUX:    avs_readdata <= aux;
				REG_PFC:    avs_readdata <= {23'h000000, pin_function_ctrl};
				REG_STAT:   avs_readdata <= {8'h00, data_s, 6'h00,
					ebl_s, boot};
				default:    avs_readdata <= '0;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			ctrl <= CTRL_RESET;
			pin_function_ctrl  <= PFC_RESET;
		end else if (avs_write && bus_done) begin
			for (int b = 0; b < 4; b++) begin
				if (avs_byteenable[b] && avs_address == REG_CTRL) begin
					ctrl[b*8 +: 8] <= avs_writedata[b*8 +: 8];
				end
			end
			if (avs_address == REG_PFC) begin
				if (avs_byteenable[0]) begin
					pin_function_ctrl[7:0] <= avs_writedata[7:0];
				end
				if (avs_byteenable[1]) begin
					pin_function_ctrl[8] <= avs_writedata[8];
				end
			end
		end
	end

	// Host write after a bus write in the same cycle takes precedence
	always_ff @(posedge clock) begin
		if (rst) begin
			window <= '0;
			aux    <= '0;
		end else begin
			for (int b = 0; b < 4; b++) begin
				if (avs_write && bus_done && avs_byteenable[b]) begin
					if (avs_address == REG_WINDOW) begin
						window[b*8 +: 8] <= avs_writedata[b*8 +: 8];
					end
					if (avs_address == REG_AUX) begin
						aux[b*8 +: 8] <= avs_writedata[b*8 +: 8];
					end
				end
			end
			if (host_commit && rsel_s) begin
				window <= win_merged;
			end else if (host_commit) begin
				aux <= aux_merged;
			end
		end
	end

	// DMA request set by software wins over a clear by the host
	always_ff @(posedge clock) begin
		if (rst) begin
			dreq_flag <= 1'b0;
		end else if (avs_write && bus_done && avs_address == REG_CTRL
			&& avs_byteenable[0] && avs_writedata[CTRL_DREQ]) begin
			dreq_flag <= 1'b1;
		end else if ((host_commit || host_rd_start) && rsel_s) begin
			dreq_flag <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------
	// Ready drops while a host write strobe is seen
	always_ff @(posedge clock) begin
		if (rst) begin
			ready_out <= 1'b0;
			ready_oe  <= pin_s[P_BOOT];
		end else begin
			ready_out <= ~(sel_s & wr_s);
			ready_oe  <= next_gate[G_READY];
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			irq_out         <= 1'b0;
			irq_oe          <= 1'b0;
			dma_request_out <= 1'b0;
			dma_request_oe  <= 1'b0;
			pin_in_buf_en   <= '0;
		end else begin
			irq_out         <= ctrl[CTRL_IRQ];
			irq_oe          <= next_gate[G_IRQ];
			dma_request_out <= dreq_flag;
			dma_request_oe  <= next_gate[G_DREQ];
			pin_in_buf_en   <= next_gate;
		end
	end

	// Data pins driven only during a gated host read
	always_ff @(posedge clock) begin
		if (rst) begin
			host_data_pins_oe  <= 1'b0;
			host_data_pins_out <= '0;
		end else begin
			host_data_pins_oe  <= sel_s & rd_s & strobes_on
				& next_gate[G_DATA];
			host_data_pins_out <= rsel_s ? win_pins : aux_pins;
		end
	end

endmodule : hpag_top

// [hpag_asserts.sv]
// Concurrent checks on the host port block ports
module hpag_asserts
	import hpag_pkg::*;
(
	input wire logic        clock,
	input wire logic        rst,
	input wire logic [2:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        port_enable_in,
	input wire logic        port_select_in,
	input wire logic        read_strobe_in,
	input wire logic        host_data_pins_oe,
	input wire logic        ready_out,
	input wire logic        ready_oe,
	input wire logic        irq_oe,
	input wire logic        dma_request_oe,
	input wire logic [7:0]  pin_in_buf_en
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	a_reset_low: assert property (disable iff (1'b0)
		rst && $past(rst) |-> !ready_out && !irq_oe && !dma_request_oe &&
		!host_data_pins_oe && pin_in_buf_en == 8'h00)
		else $error("outputs active during reset");
	a_wait_one: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
	a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("wait low too long");
	a_read_hold: assert property (!avs_read |=> $stable(avs_readdata))
		else $error("read data moved");
	a_unmapped_read: assert property (
		avs_read && avs_waitrequest && avs_address > REG_STAT
		|=> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	a_enable_off: assert property (!port_enable_in [*3] |=>
		pin_in_buf_en == 8'h00 && !ready_oe && !irq_oe &&
		!dma_request_oe && !host_data_pins_oe)
		else $error("pins active with enable low");
	a_ready_gate: assert property (
		ready_oe && !$past(rst) |-> $past(port_enable_in, 3))
		else $error("ready driven without enable");
	a_out_gate: assert property (
		(irq_oe || dma_request_oe || host_data_pins_oe) && !$past(rst)
		|-> $past(port_enable_in, 3))
		else $error("outputs driven without enable");
	a_drive_read: assert property (host_data_pins_oe |->
		$past(read_strobe_in, 3) && $past(port_select_in, 3))
		else $error("data driven without read");
endmodule : hpag_asserts

// [hpag_host_model.sv]
// External host model driving the port strobes and data pins
module hpag_host_model (
	input  wire logic        clock,
	input  wire logic [15:0] pins_out,
	input  wire logic        pins_oe,
	input  wire logic        ready,
	output logic             sel,
	output logic             rsel,
	output logic             wr,
	output logic             rd,
	output logic      [15:0] data_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] idle;
	logic [15:0] drive;
	logic        driving;

	initial begin
		drive = 16'h0000;
		driving = 1'b0;
		sel = 1'b0;
		rsel = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		idle = 16'hA5C3;
	end
	// Released pins show a changing pattern, never a held value
	always @(posedge clock)
		idle <= ~idle;
	assign data_in = driving ? drive : (pins_oe ? pins_out : idle);

	// Write holds select and data until the trailing strobe edge is taken
	task automatic write_half(input logic rs, input logic [15:0] d,
			output logic ok);
		@(posedge clock);
		sel <= 1'b1;
		rsel <= rs;
		wr <= 1'b1;
		drive <= d;
		driving <= 1'b1;
		ok = 1'b0;
		for (int n = 0; n < 20 && !ok; n++) begin
			@(posedge clock);
			ok = (ready === 1'b0);
		end
		wr <= 1'b0;
		repeat (3) @(posedge clock);
		sel <= 1'b0;
		driving <= 1'b0;
		repeat (5) @(posedge clock);
	endtask : write_half

	task automatic read_half(input logic rs, output logic [15:0] d,
			output logic ok);
		@(posedge clock);
		sel <= 1'b1;
		rsel <= rs;
		rd <= 1'b1;
		ok = 1'b0;
		for (int n = 0; n < 20 && !ok; n++) begin
			@(posedge clock);
			ok = (pins_oe === 1'b1);
		end
		d = pins_out;
		sel <= 1'b0;
		rd <= 1'b0;
		repeat (5) @(posedge clock);
	endtask : read_half
endmodule : hpag_host_model

// [tb.sv]
// Self-checking bench for the host port alignment and pin guard
module tb import hpag_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clock, rst, avs_read, avs_write, avs_waitrequest;
	logic        boot_mode_in, port_enable_in, port_select_in;
	logic        register_select_in, write_strobe_in, read_strobe_in;
	logic        host_data_pins_oe, ready_out, ready_oe, irq_out, irq_oe;
	logic        dma_request_out, dma_request_oe;
	logic [2:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, rdata;
	logic [15:0] host_data_pins_in, host_data_pins_out;
	logic [7:0]  pin_in_buf_en;
	int          miscompares, comparisons;

	hpag_top hpag_top_i (.clock, .rst, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
		.avs_waitrequest, .boot_mode_in, .port_enable_in, .port_select_in,
		.register_select_in, .write_strobe_in, .read_strobe_in,
		.host_data_pins_in, .host_data_pins_out, .host_data_pins_oe,
		.ready_out, .ready_oe, .irq_out, .irq_oe, .dma_request_out,
		.dma_request_oe, .pin_in_buf_en);
	hpag_host_model hpag_host_model_i (.clock, .pins_out(host_data_pins_out),
		.pins_oe(host_data_pins_oe), .ready(ready_out),
		.sel(port_select_in),
		.rsel(register_select_in), .wr(write_strobe_in),
		.rd(read_strobe_in), .data_in(host_data_pins_in));

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	// ------------------------------------------------------------
	// Checking and bus tasks
	// ------------------------------------------------------------
	task complete_run;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : complete_run

	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic bus(input logic w, input logic [2:0] a,
			input logic [31:0] d);
		int n;
		@(posedge clock);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		for (n = 0; n < 40; n++) begin
			@(posedge clock);
			if (avs_waitrequest === 1'b0)
				break;
		end
		rdata = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n == 40) begin
			miscompares++;
			complete_run();
		end
	endtask : bus

	task rst_run(input logic b);
		boot_mode_in <= b;
		rst <= 1'b1;
		repeat (12) @(posedge clock);
		chk({ready_oe, ready_out}, {b, 1'b0});
		chk({irq_oe, host_data_pins_oe, pin_in_buf_en}, 10'h000);
		rst <= 1'b0;
		repeat (5) @(posedge clock);
	endtask : rst_run

	function automatic logic [31:0] rev(logic [31:0] w, logic on);
		return on ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
	endfunction : rev

	function automatic logic [15:0] exp_pins(logic [31:0] w, logic sw,
			logic o, logic [1:0] h, logic win);
		logic [31:0] v;
		v = rev(w, sw && win);
		return (h[1] == o) ? v[31:16] : v[15:0];
	endfunction : exp_pins

	// Register after a host write of one half with the same alignment
	function automatic logic [31:0] exp_word(logic [31:0] w,
			logic [15:0] p, logic sw, logic o, logic [1:0] h, logic win);
		logic [31:0] v;
		v = rev(w, sw && win);
		if (h[1] == o)
			v[31:16] = p;
		else
			v[15:0] = p;
		return rev(v, sw && win);
	endfunction : exp_word

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		logic [31:0] w;
		logic [15:0] d;
		logic [15:0] p;
		logic [1:0]  h;
		logic        ok;
		rst = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 3'h0;
		avs_writedata = 32'h0;
		boot_mode_in = 1'b1;
		port_enable_in = 1'b1;
		miscompares = 0;
		comparisons = 0;
		w = $urandom(77);
		rst_run(1'b1);
		chk({ready_oe, irq_oe, dma_request_oe, pin_in_buf_en}, 11'h7FF);
		bus(1'b0, REG_STAT, 32'h0);
		chk(rdata[1:0], 2'h3);
		bus(1'b0, REG_PFC, 32'h0);
		chk(rdata, 32'h0);
		w = $urandom;
		bus(1'b1, REG_AUX, w);
		bus(1'b0, REG_AUX, 32'h0);
		chk(rdata, w);
		bus(1'b1, 3'h7, w);
		bus(1'b0, 3'h7, 32'h0);
		chk(rdata, 32'h0);
		for (int i = 0; i < 16; i++) begin
			w = (i % 3 == 0) ? 32'h76543210 : $urandom;
			h = {i[2], 1'($urandom)};
			bus(1'b1, i[3] ? REG_WINDOW : REG_AUX, w);
			bus(1'b1, REG_CTRL, {28'h0, h, i[1], i[0]});
			hpag_host_model_i.read_half(i[3], d, ok);
			chk(ok, 1'b1);
			chk(d, exp_pins(w, i[0], i[1], h, i[3]));
		end
		// Host writes one half, then bus and host read it back
		for (int i = 0; i < 8; i++) begin
			w = $urandom;
			p = 16'($urandom);
			h = 2'($urandom);
			bus(1'b1, i[0] ? REG_WINDOW : REG_AUX, w);
			bus(1'b1, REG_CTRL, {26'h0, 1'b1, i[2] ^ i[1], h, i[1], i[2]});
			hpag_host_model_i.write_half(i[0], p, ok);
			chk(ok, 1'b1);
			chk(ready_out, 1'b1);
			chk(irq_out, i[2] ^ i[1]);
			chk(dma_request_out, !i[0]);
			bus(1'b0, i[0] ? REG_WINDOW : REG_AUX, 32'h0);
			chk(rdata, exp_word(w, p, i[2], i[1], h, i[0]));
			hpag_host_model_i.read_half(i[0], d, ok);
			chk(d, p);
		end
		// Power monitor cuts the far side
		port_enable_in <= 1'b0;
		hpag_host_model_i.read_half(1'b1, d, ok);
		chk(ok, 1'b0);
		chk({ready_oe, irq_oe, dma_request_oe, pin_in_buf_en}, 32'h0);
		port_enable_in <= 1'b1;
		rst_run(1'b0);
		chk({ready_oe, irq_oe, dma_request_oe, pin_in_buf_en}, 32'h0);
		bus(1'b1, REG_PFC, 32'h1FF);
		repeat (5) @(posedge clock);
		chk(pin_in_buf_en, 8'hFF);
		port_enable_in <= 1'b0;
		repeat (5) @(posedge clock);
		chk(pin_in_buf_en, 8'h00);
		port_enable_in <= 1'b1;
		bus(1'b1, REG_PFC, 32'h1FE);
		repeat (5) @(posedge clock);
		chk({ready_oe, irq_oe, pin_in_buf_en}, 32'h0);
		complete_run();
	end
endmodule : tb

bind hpag_top hpag_asserts hpag_asserts_i (.clock, .rst, .avs_address,
	.avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .port_enable_in,
	.port_select_in, .read_strobe_in, .host_data_pins_oe, .ready_out,
	.ready_oe, .irq_oe, .dma_request_oe, .pin_in_buf_en);
